// ==== rtl/odt_decoder.v ====
/*
 instruction decoder for the 16-bit core: prefixes, addressing form
 byte, displacement, operand location, segment choice, and minimum
 clock counts for logic, string, control and flag instructions.
 assumes a prefetch queue on the same clock presenting one byte with
 a valid flag; a byte is consumed in any fetch-state cycle with q_valid_i high, and byte_take_o is high the cycle after.
 word registers: 0 ax,1 cx,2 dx,3 bx,4 sp,5 bp,6 si,7 di.
*/
`timescale 1ns/10ps
`include "odt_defs.vh"
// Overview of operation
// - form 11 means operand is register
// - form 01 one byte displacement, sign-extended
// - form 10 two byte displacement, low first
// - selector codes pick base/index pairs plus displacement
// - form 00 selector 110 is direct address
// - operand location adds no counted clocks
// - displacement precedes immediate data bytes
// - segment prefix 001rr110 picks segment
// - byte register codes pass out as raw 3-bit codes
// - frame base pointer operands use stack
// - string destination always uses extra segment
// - flag-only AND writes no result
// - iterate prefix repeats by count; copy 8+8n
// - short conditional jumps cost 4/13; only BEQ (74h) is ever taken, the others always cost 4
// - count loop decrements, costs 6/16
// - branch on count empty costs 5/15
// - overflow trap costs 48/4
// - lock prefix locks next instruction, 2 clocks
// - far return with immediate, 25 clocks
// - carry toggle and flag ops, 2 clocks
// - block fill stores accumulator, 10 clocks
module odt_decoder (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        sys_rst_i,
    // prefetch queue
    input  wire [7:0]  q_byte_i,
    input  wire        q_valid_i,
    output reg         byte_take_o,
    // processor flags from execution
    input  wire        flag_zero_i,
    input  wire        flag_ovf_i,
    // decoded instruction
    output reg         done_o,
    output reg  [7:0]  opcode_o,
    output reg  [7:0]  clocks_o,
    output reg         word_op_o,
    output reg         reg_operand_o,
    output reg  [2:0]  reg_sel_o,
    output reg  [2:0]  rm_reg_o,
    output reg  [15:0] operand_location_o,
    output reg  [1:0]  seg_sel_o,
    output reg  [1:0]  dst_seg_o,
    output reg  [15:0] imm_o,
    output reg         result_write_o,
    output reg         branch_taken_o,
    output reg         trap_o,
    output reg         bus_lock_o,
    output reg         carry_toggle_o,
    // register file write for tests and execution loading
    input  wire        rf_wr_en_i,
    input  wire [2:0]  rf_wr_idx_i,
    input  wire [15:0] rf_wr_data_i,
    output reg  [15:0] count_register_o
);
    // decoder states
    localparam ST_OP   = 3'd0;
    localparam ST_MRM  = 3'd1;
    localparam ST_DLO  = 3'd2;
    localparam ST_DHI  = 3'd3;
    localparam ST_ILO  = 3'd4;
    localparam ST_IHI  = 3'd5;
    localparam ST_EA   = 3'd6;
    localparam ST_FIN  = 3'd7;

    reg  [2:0]  state;
    reg  [7:0]  op;
    reg  [7:0]  mrm;
    reg  [15:0] disp;
    reg  [15:0] imm;
    reg  [1:0]  seg_ovr;
    reg         seg_ovr_v;
    reg         lock_pend;
    reg         iter_pend;
    reg  [7:0]  pfx_clk;
    reg         has_mrm;
    reg         imm_any;
    reg  [15:0] cnt_reg;

    wire [15:0] rd_a;
    wire [15:0] rd_b;
    wire        take = q_valid_i;
    wire [1:0]  f_mod = mrm[`ODT_MOD_HI:`ODT_MOD_LO];
    wire [2:0]  f_rm  = mrm[`ODT_RM_HI:`ODT_RM_LO];

    // base and index word indices for the operand location
    function [5:0] ea_regs;
        input [2:0] rm;
        begin
            case (rm)
                3'd0:    ea_regs = {3'd3, 3'd6};
                3'd1:    ea_regs = {3'd3, 3'd7};
                3'd2:    ea_regs = {3'd5, 3'd6};
                3'd3:    ea_regs = {3'd5, 3'd7};
                3'd4:    ea_regs = {3'd6, 3'd6};
                3'd5:    ea_regs = {3'd7, 3'd7};
                3'd6:    ea_regs = {3'd5, 3'd5};
                default: ea_regs = {3'd3, 3'd3};
            endcase
        end
    endfunction

    // true when selector uses only one register
    function single_reg;
        input [2:0] rm;
        begin
            single_reg = rm[2];
        end
    endfunction

    // true when frame base pointer takes part
    function uses_frame;
        input [1:0] md;
        input [2:0] rm;
        begin
            uses_frame = (rm == 3'd2) || (rm == 3'd3) ||
                         ((rm == `ODT_RM_DIRECT) &&
                          (md != `ODT_MOD_NODISP));
        end
    endfunction

    wire [5:0]  ea_pair = ea_regs((state == ST_MRM) ? q_byte_i[2:0] : f_rm);

    odt_regfile #(
        .WIDTH (16)
    ) u_rf (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .wr_en_i   (rf_wr_en_i),
        .wr_idx_i  (rf_wr_idx_i),
        .wr_data_i (rf_wr_data_i),
        .rd_a_idx_i(ea_pair[5:3]),
        .rd_b_idx_i(ea_pair[2:0]),
        .rd_a_o    (rd_a),
        .rd_b_o    (rd_b)
    );

    // shadow of the count register for branch decisions
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 16'h0000;
        end else if (rf_wr_en_i && (rf_wr_idx_i == 3'd1)) begin
            cnt_reg <= rf_wr_data_i;
        end else if (state == ST_FIN && op == `ODT_OP_LOOP) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end
    end

    // classify the opcode that just arrived
    always @* begin
        has_mrm    = 1'b0;
        imm_any    = 1'b0;
        if (q_byte_i[7:1] == `ODT_OP_TEST_RM) begin
            has_mrm = 1'b1;
        end
        if (q_byte_i == `ODT_OP_RETFI) begin
            imm_any    = 1'b1;
        end
        if (q_byte_i[7:4] == `ODT_OP_JCC_HI ||
            q_byte_i == `ODT_OP_LOOP || q_byte_i == `ODT_OP_BCXZ) begin
            imm_any = 1'b1;
        end
    end

    // main sequencer
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state <= ST_OP; op <= 8'h00; mrm <= 8'h00;
            disp <= 16'h0000; imm <= 16'h0000;
            seg_ovr <= 2'b00; seg_ovr_v <= 1'b0;
            lock_pend <= 1'b0; iter_pend <= 1'b0; pfx_clk <= 8'h00;
            byte_take_o <= 1'b0; done_o <= 1'b0; opcode_o <= 8'h00;
            clocks_o <= 8'h00; word_op_o <= 1'b0; reg_operand_o <= 1'b0;
            reg_sel_o <= 3'd0; rm_reg_o <= 3'd0;
            operand_location_o <= 16'h0000; seg_sel_o <= 2'b11;
            dst_seg_o <= 2'b00; imm_o <= 16'h0000;
            result_write_o <= 1'b0; branch_taken_o <= 1'b0;
            trap_o <= 1'b0; bus_lock_o <= 1'b0; carry_toggle_o <= 1'b0;
            count_register_o <= 16'h0000;
        end else begin
            done_o         <= 1'b0;
            byte_take_o    <= 1'b0;
            trap_o         <= 1'b0;
            carry_toggle_o <= 1'b0;
            count_register_o <= cnt_reg;
            case (state)
                ST_OP: if (take) begin
                    byte_take_o <= 1'b1;
                    if (q_byte_i[7:5] == `ODT_OP_SEGPFX_HI &&
                        q_byte_i[2:0] == `ODT_OP_SEGPFX_LO) begin
                        seg_ovr   <= q_byte_i[4:3];
                        seg_ovr_v <= 1'b1;
                        pfx_clk   <= pfx_clk + `ODT_CLK_FLAG;
                    end else if (q_byte_i == `ODT_OP_LOCK) begin
                        lock_pend <= 1'b1;
                        pfx_clk   <= pfx_clk + `ODT_CLK_LOCK;
                    end else if (q_byte_i[7:1] == `ODT_OP_ITER) begin
                        iter_pend <= 1'b1;
                    end else begin
                        op <= q_byte_i;
                        word_op_o  <= q_byte_i[0];
                        bus_lock_o <= lock_pend;
                        if (has_mrm) begin
                            state <= ST_MRM;
                        end else if (imm_any) begin
                            state <= ST_ILO;
                        end else begin
                            state <= ST_FIN;
                        end
                    end
                end
                ST_MRM: if (take) begin
                    byte_take_o <= 1'b1;
                    mrm  <= q_byte_i;
                    disp <= 16'h0000;
                    case (q_byte_i[`ODT_MOD_HI:`ODT_MOD_LO])
                        `ODT_MOD_DISP8:  state <= ST_DLO;
                        `ODT_MOD_DISP16: state <= ST_DLO;
                        `ODT_MOD_NODISP: state <=
                            (q_byte_i[2:0] == `ODT_RM_DIRECT) ?
                            ST_DLO : ST_EA;
                        default:         state <= ST_FIN;
                    endcase
                end
                ST_DLO: if (take) begin
                    byte_take_o <= 1'b1;
                    if (f_mod == `ODT_MOD_DISP8) begin
                        disp  <= {{8{q_byte_i[7]}}, q_byte_i};
                        state <= ST_EA;
                    end else begin
                        disp[7:0] <= q_byte_i;
                        state     <= ST_DHI;
                    end
                end
                ST_DHI: if (take) begin
                    byte_take_o <= 1'b1;
                    disp[15:8]  <= q_byte_i;
                    state       <= ST_EA;
                end
                ST_EA: begin
                    if (f_mod == `ODT_MOD_NODISP &&
                        f_rm == `ODT_RM_DIRECT) begin
                        operand_location_o <= disp;
                    end else if (single_reg(f_rm)) begin
                        operand_location_o <= rd_a + disp;
                    end else begin
                        operand_location_o <= rd_a + rd_b + disp;
                    end
                    state <= ST_FIN;
                end
                ST_ILO: if (take) begin
                    byte_take_o <= 1'b1;
                    imm <= {{8{q_byte_i[7]}}, q_byte_i};
                    state <= (op == `ODT_OP_RETFI) ? ST_IHI : ST_FIN;
                end
                ST_IHI: if (take) begin
                    byte_take_o <= 1'b1;
                    imm[15:8]   <= q_byte_i;
                    state       <= ST_FIN;
                end
                ST_FIN: begin
                    done_o   <= 1'b1;
                    opcode_o <= op;
                    imm_o    <= imm;
                    reg_sel_o <= mrm[`ODT_REG_HI:`ODT_REG_LO];
                    rm_reg_o  <= f_rm;
                    reg_operand_o <= has_mrm_op(op) &&
                                     (f_mod == `ODT_MOD_REG);
                    if (seg_ovr_v) begin
                        seg_sel_o <= seg_ovr;
                    end else if (uses_frame(f_mod, f_rm)) begin
                        seg_sel_o <= `ODT_SEG_STACK;
                    end else begin
                        seg_sel_o <= `ODT_SEG_DATA;
                    end
                    dst_seg_o <= `ODT_SEG_EXTRA;
                    result_write_o <= (op[7:1] == `ODT_OP_FILL) ||
                                      (op[7:1] == `ODT_OP_COPY);
                    branch_taken_o <= 1'b0;
                    clocks_o <= pfx_clk;
                    if (op[7:1] == `ODT_OP_TEST_RM) begin
                        clocks_o <= pfx_clk + ((f_mod == `ODT_MOD_REG) ?
                                    `ODT_CLK_TEST_R : `ODT_CLK_TEST_M);
                    end else if (op[7:4] == `ODT_OP_JCC_HI) begin
                        branch_taken_o <= (op == `ODT_OP_BEQ) &&
                                          flag_zero_i;
                        clocks_o <= pfx_clk + (((op == `ODT_OP_BEQ) &&
                                    flag_zero_i) ? `ODT_CLK_JCC_T :
                                    `ODT_CLK_JCC_NT);
                    end else if (op == `ODT_OP_LOOP) begin
                        branch_taken_o <= (cnt_reg != 16'h0001);
                        clocks_o <= pfx_clk + ((cnt_reg != 16'h0001) ?
                                    `ODT_CLK_LOOP_T : `ODT_CLK_LOOP_NT);
                    end else if (op == `ODT_OP_BCXZ) begin
                        branch_taken_o <= (cnt_reg == 16'h0000);
                        clocks_o <= pfx_clk + ((cnt_reg == 16'h0000) ?
                                    `ODT_CLK_CXZ_T : `ODT_CLK_CXZ_NT);
                    end else if (op == `ODT_OP_INTO) begin
                        trap_o   <= flag_ovf_i;
                        clocks_o <= pfx_clk + (flag_ovf_i ?
                                    `ODT_CLK_INTO_T : `ODT_CLK_INTO_NT);
                    end else if (op == `ODT_OP_RETFI) begin
                        clocks_o <= pfx_clk + `ODT_CLK_RETFI;
                    end else if (op == `ODT_OP_CTOG) begin
                        carry_toggle_o <= 1'b1;
                        clocks_o <= pfx_clk + `ODT_CLK_FLAG;
                    end else if (op >= `ODT_OP_CLC &&
                                 op <= `ODT_OP_STD) begin
                        clocks_o <= pfx_clk + `ODT_CLK_FLAG;
                    end else if (op[7:1] == `ODT_OP_FILL) begin
                        clocks_o <= pfx_clk + `ODT_CLK_FILL;
                    end else if (op[7:1] == `ODT_OP_COPY &&
                                 iter_pend) begin
                        clocks_o <= pfx_clk + `ODT_CLK_COPY_B +
                                    (`ODT_CLK_COPY_N * cnt_reg[7:0]);
                    end
                    seg_ovr_v <= 1'b0;
                    lock_pend <= 1'b0;
                    iter_pend <= 1'b0;
                    pfx_clk   <= 8'h00;
                    mrm       <= 8'h00;
                    state     <= ST_OP;
                end
                default: state <= ST_OP;
            endcase
        end
    end

    // opcodes decoded here that carry an addressing form byte
    function has_mrm_op;
        input [7:0] o;
        begin
            has_mrm_op = (o[7:1] == `ODT_OP_TEST_RM);
        end
    endfunction
endmodule

// ==== common/odt_defs.vh ====
/*
 decode constants for the opcode decode and timing block: opcodes,
 field positions, segment codes and minimum clock counts.
 assumes inclusion by bare name from rtl files.
*/
`ifndef ODT_DEFS_VH
`define ODT_DEFS_VH

// addressing form byte field positions
`define ODT_MOD_HI      7
`define ODT_MOD_LO      6
`define ODT_REG_HI      5
`define ODT_REG_LO      3
`define ODT_RM_HI       2
`define ODT_RM_LO       0

// addressing form codes
`define ODT_MOD_NODISP  2'b00
`define ODT_MOD_DISP8   2'b01
`define ODT_MOD_DISP16  2'b10
`define ODT_MOD_REG     2'b11
`define ODT_RM_DIRECT   3'b110

// segment codes
`define ODT_SEG_EXTRA   2'b00
`define ODT_SEG_CODE    2'b01
`define ODT_SEG_STACK   2'b10
`define ODT_SEG_DATA    2'b11

// opcodes
`define ODT_OP_LOCK     8'hf0
`define ODT_OP_CTOG     8'hf5
`define ODT_OP_BEQ      8'h74
`define ODT_OP_LOOP     8'he2
`define ODT_OP_BCXZ     8'he3
`define ODT_OP_INTO     8'hce
`define ODT_OP_RETFI    8'hca
`define ODT_OP_CLC      8'hf8
`define ODT_OP_STC      8'hf9
`define ODT_OP_CLI      8'hfa
`define ODT_OP_STI      8'hfb
`define ODT_OP_CLD      8'hfc
`define ODT_OP_STD      8'hfd
`define ODT_OP_TEST_RM  7'h42
`define ODT_OP_FILL     7'h55
`define ODT_OP_COPY     7'h52
`define ODT_OP_ITER     7'h79
`define ODT_OP_SEGPFX_HI 3'b001
`define ODT_OP_SEGPFX_LO 3'b110
`define ODT_OP_JCC_HI   4'h7

// minimum clock counts
`define ODT_CLK_EA      8'h04
`define ODT_CLK_FLAG    8'h02
`define ODT_CLK_LOCK    8'h02
`define ODT_CLK_JCC_NT  8'h04
`define ODT_CLK_JCC_T   8'h0d
`define ODT_CLK_LOOP_NT 8'h06
`define ODT_CLK_LOOP_T  8'h10
`define ODT_CLK_CXZ_NT  8'h05
`define ODT_CLK_CXZ_T   8'h0f
`define ODT_CLK_INTO_T  8'h30
`define ODT_CLK_INTO_NT 8'h04
`define ODT_CLK_RETFI   8'h19
`define ODT_CLK_FILL    8'h0a
`define ODT_CLK_COPY_B  8'h08
`define ODT_CLK_COPY_N  8'h08
`define ODT_CLK_TEST_R  8'h03
`define ODT_CLK_TEST_M  8'h0a

`endif

// ==== rtl/odt_regfile.v ====
/*
 small general register file of eight 16-bit words, word access only,
 read data registered.
 assumes one write port driven by the decoder on the same clock.
*/
`timescale 1ns/10ps
module odt_regfile #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             ref_clk_i,
    input  wire             sys_rst_i,
    // write port
    input  wire             wr_en_i,
    input  wire [2:0]       wr_idx_i,
    input  wire [WIDTH-1:0] wr_data_i,
    // read ports
    input  wire [2:0]       rd_a_idx_i,
    input  wire [2:0]       rd_b_idx_i,
    output reg  [WIDTH-1:0] rd_a_o,
    output reg  [WIDTH-1:0] rd_b_o
);
    reg [WIDTH-1:0] mem [0:7];
    integer k;

    // write and registered read; reset clears all words
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            for (k = 0; k < 8; k = k + 1) begin
                mem[k] <= {WIDTH{1'b0}};
            end
            rd_a_o <= {WIDTH{1'b0}};
            rd_b_o <= {WIDTH{1'b0}};
        end else begin
            if (wr_en_i) begin
                mem[wr_idx_i] <= wr_data_i;
            end
            rd_a_o <= mem[rd_a_idx_i];
            rd_b_o <= mem[rd_b_idx_i];
        end
    end
endmodule

// ==== verification/odt_decoder_properties.sv ====
/*
 checker for the decoder: clock counts, pulses and segment choice.
 assumes binding to odt_decoder; sees its ports only.
*/
`timescale 1ns/10ps
module odt_decoder_properties (
    // clock and reset
    input wire       ref_clk_i,
    input wire       sys_rst_i,
    // decoded instruction
    input wire       done_o,
    input wire [7:0] opcode_o,
    input wire [7:0] clocks_o,
    input wire       word_op_o,
    input wire       result_write_o,
    input wire       branch_taken_o,
    input wire       trap_o,
    input wire       bus_lock_o,
    input wire       carry_toggle_o,
    input wire [1:0] dst_seg_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    // finish of one opcode, and the toggle pulse starting in the same cycle
    sequence s_ctog_fin;
        done_o && opcode_o == 8'hf5;
    endsequence
    sequence s_pulse_once;
        carry_toggle_o ##1 !carry_toggle_o;
    endsequence

    AST_TEST_NO_WRITE: assert property (
        done_o && opcode_o[7:1] == 7'h42 |-> !result_write_o)
        else $error("flag-only and wrote a result");
    AST_JCC_CLOCKS: assert property (
        done_o && opcode_o == 8'h74 |->
        clocks_o == (branch_taken_o ? 8'h0d : 8'h04))
        else $error("short jump clock count wrong");
    AST_LOOP_CLOCKS: assert property (
        done_o && opcode_o == 8'he2 |->
        clocks_o == (branch_taken_o ? 8'h10 : 8'h06))
        else $error("count loop clock count wrong");
    AST_CXZ_CLOCKS: assert property (
        done_o && opcode_o == 8'he3 |->
        clocks_o == (branch_taken_o ? 8'h0f : 8'h05))
        else $error("count empty branch clock count wrong");
    AST_TRAP_CLOCKS: assert property (
        done_o && opcode_o == 8'hce |->
        clocks_o == (trap_o ? 8'h30 : 8'h04))
        else $error("overflow trap clock count wrong");
    AST_TRAP_ONLY: assert property (
        trap_o |-> done_o && opcode_o == 8'hce)
        else $error("trap without overflow trap opcode");
    AST_RETFI_CLOCKS: assert property (
        done_o && opcode_o == 8'hca |-> clocks_o == 8'h19)
        else $error("far return clock count wrong");
    AST_FLAG_CLOCKS: assert property (
        done_o && (opcode_o == 8'hf5 || opcode_o inside {[8'hf8:8'hfd]})
        |-> clocks_o == (bus_lock_o ? 8'h04 : 8'h02))
        else $error("flag operation clock count wrong");
    AST_CTOG_PULSE: assert property (
        s_ctog_fin |-> s_pulse_once)
        else $error("carry toggle pulse missing or long");
    AST_DST_SEG: assert property (
        done_o |-> dst_seg_o == 2'b00)
        else $error("string destination segment not extra");
    AST_WORD_BIT: assert property (
        done_o |-> word_op_o == opcode_o[0])
        else $error("operand size does not follow opcode bit");
endmodule

bind odt_decoder odt_decoder_properties chk_u (.*);

// ==== verification/odt_queue_model.sv ====
/*
 prefetch queue model: bytes held in an array, one offered at a time.
 assumes the bench fills mem and len; take pulse lags one cycle.
*/
`timescale 1ns/10ps
module odt_queue_model (
    // clock and reset
    input  wire       ref_clk_i,
    input  wire       sys_rst_i,
    // decoder side
    input  wire       byte_take_i,
    input  wire       stall_i,
    output wire [7:0] q_byte_o,
    output wire       q_valid_o
);
    reg  [7:0] mem [0:255];
    reg  [7:0] len;
    reg  [7:0] ptr;
    reg  [7:0] last;
    reg        hold;
    // skip the byte already taken, as the take report is late
    wire [7:0] rd = ptr + {7'h00, byte_take_i};

    // empty or stalled queue shows a changing, wrong byte
    assign q_valid_o = (rd != len) && !hold;
    assign q_byte_o  = q_valid_o ? mem[rd] : ~last;

    // pointer advance and stall sampled at the edge
    always @(posedge ref_clk_i) begin
        hold <= stall_i;
        last <= q_byte_o;
        if (sys_rst_i)
            ptr <= 8'h00;
        else
            ptr <= rd;
    end
endmodule

// ==== verification/test_opcode_decode_timing.sv ====
/*
 self-checking bench for the decoder, fed by the queue model.
 assumes 100 MHz clock and synchronous active high reset.
*/
`timescale 1ns/10ps
module test_opcode_decode_timing;
    localparam [15:0] v_bx = 16'h1000, v_si = 16'h0020;
    localparam [15:0] v_dix = 16'h0300, v_fbp = 16'h2000;
    reg         ref_clk = 1'b0, sys_rst = 1'b1, zf = 1'b0, ovf = 1'b0;
    reg         rf_en = 1'b0, stall = 1'b0, slow = 1'b0;
    reg  [2:0]  rf_idx = 3'h0;
    reg  [15:0] rf_data = 16'h0000;
    wire [7:0]  q_byte, opcode, clocks;
    wire        q_valid, take, done, word, reg_op, rw, taken;
    wire        trap, lock, ctog;
    wire [2:0]  reg_sel, rm_reg;
    wire [1:0]  seg, dseg;
    wire [15:0] loc, imm, cnt;
    integer     num_errors = 0, num_checks = 0, wp = 0;

    always #5 ref_clk = ~ref_clk;

    odt_queue_model q_u (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .byte_take_i(take),
        .stall_i(stall), .q_byte_o(q_byte), .q_valid_o(q_valid)
    );
    odt_decoder dut_u (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .q_byte_i(q_byte),
        .q_valid_i(q_valid), .byte_take_o(take), .flag_zero_i(zf),
        .flag_ovf_i(ovf), .done_o(done), .opcode_o(opcode),
        .clocks_o(clocks), .word_op_o(word), .reg_operand_o(reg_op),
        .reg_sel_o(reg_sel), .rm_reg_o(rm_reg),
        .operand_location_o(loc), .seg_sel_o(seg), .dst_seg_o(dseg),
        .imm_o(imm), .result_write_o(rw), .branch_taken_o(taken),
        .trap_o(trap), .bus_lock_o(lock), .carry_toggle_o(ctog),
        .rf_wr_en_i(rf_en), .rf_wr_idx_i(rf_idx),
        .rf_wr_data_i(rf_data), .count_register_o(cnt)
    );

    task check(input [15:0] seen, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // bytes stay hidden from the queue until run releases them
    task put(input [7:0] b);
        begin
            q_u.mem[wp] = b;
            wp = wp + 1;
        end
    endtask
    task run;
        integer n;
        begin
            @(posedge ref_clk);
            q_u.len <= wp[7:0];
            stall <= slow;
            n = 0;
            @(negedge ref_clk);
            while (done !== 1'b1 && n < 60) begin
                @(negedge ref_clk);
                n = n + 1;
                if (n == 3)
                    stall <= 1'b0;
            end
            check(done, 1'b1);
        end
    endtask
    task setreg(input [2:0] idx, input [15:0] v);
        begin
            @(posedge ref_clk);
            rf_en <= 1'b1;
            rf_idx <= idx;
            rf_data <= v;
            @(posedge ref_clk);
            rf_en <= 1'b0;
        end
    endtask
    function [15:0] base(input [2:0] rm);
        case (rm)
            3'h0: base = v_bx + v_si;
            3'h1: base = v_bx + v_dix;
            3'h2: base = v_fbp + v_si;
            3'h3: base = v_fbp + v_dix;
            3'h4: base = v_si;
            3'h5: base = v_dix;
            3'h6: base = v_fbp;
            default: base = v_bx;
        endcase
    endfunction

    task t_reg;
        begin
            put(8'h84);
            put(8'hd9);
            run;
            check(reg_op, 1'b1);
            check(rm_reg, 3'h1);
            check(reg_sel, 3'h3);
            check(rw, 1'b0);
            check(word, 1'b0);
            check(clocks, 8'h03);
        end
    endtask
    // every selector code with a two byte offset, one slow queue
    task t_ea;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                slow = (k == 4);
                put(8'h85);
                put({5'b10010, k[2:0]});
                put(8'h34);
                put(8'h12);
                run;
                check(loc, base(k[2:0]) + 16'h1234);
                check(seg, (k == 2 || k == 3 || k == 6) ? 2'h2 : 2'h3);
                check(clocks, 8'h0a);
                check(word, 1'b1);
            end
            slow = 1'b0;
        end
    endtask
    // short offset then a one byte opcode right behind it
    task t_disp8;
        begin
            put(8'h84);
            put(8'h47);
            put(8'h80);
            put(8'hf5);
            run;
            check(loc, v_bx + 16'hff80);
            run;
            check(opcode, 8'hf5);
        end
    endtask
    // four overrides, then the direct form with no prefix
    task t_seg;
        integer k;
        begin
            for (k = 0; k < 5; k = k + 1) begin
                if (k < 4)
                    put({3'b001, k[1:0], 3'b110});
                put(8'h84);
                put(8'h06);
                put(8'h78);
                put(8'h56);
                run;
                check(loc, 16'h5678);
                check(seg, k < 4 ? k[1:0] : 2'h3);
                check(clocks, k < 4 ? 8'h0c : 8'h0a);
            end
        end
    endtask
    task jmp(input [7:0] op, input z, input o, input [15:0] c,
             input [7:0] ck, input tk);
        begin
            setreg(3'h1, c);
            zf <= z;
            ovf <= o;
            put(op);
            if (op != 8'hce)
                put(8'h10);
            run;
            check(clocks, ck);
            check(op == 8'hce ? trap : taken, tk);
            repeat (2) @(negedge ref_clk);
            if (op == 8'he2)
                check(cnt, c - 16'h0001);
        end
    endtask
    task t_flags;
        integer k;
        begin
            for (k = 0; k < 7; k = k + 1) begin
                put(k == 0 ? 8'hf5 : 8'hf7 + k);
                run;
                check(clocks, 8'h02);
                check(ctog, k == 0);
            end
        end
    endtask
    task t_misc;
        begin
            put(8'hf0);
            put(8'hf8);
            run;
            check(lock, 1'b1);
            put(8'hf9);
            run;
            check(lock, 1'b0);
            put(8'hca);
            put(8'hcd);
            put(8'hab);
            run;
            check(clocks, 8'h19);
            check(imm, 16'habcd);
            put(8'haa);
            run;
            check(clocks, 8'h0a);
            put(8'h2e);
            put(8'hab);
            run;
            check(dseg, 2'h0);
            setreg(3'h1, 16'h0003);
            put(8'hf3);
            put(8'ha4);
            run;
            check(clocks, 8'h20);
        end
    endtask

    // watchdog well beyond the expected run length
    initial begin
        #200000;
        num_errors = num_errors + 1;
        test_done;
    end
    initial begin
        q_u.len = 8'h00;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        check(seg, 2'h3);
        setreg(3'h3, v_bx);
        setreg(3'h6, v_si);
        setreg(3'h7, v_dix);
        setreg(3'h5, v_fbp);
        t_reg;
        t_ea;
        t_disp8;
        t_seg;
        jmp(8'h74, 1'b0, 1'b0, 16'h0005, 8'h04, 1'b0);
        jmp(8'h74, 1'b1, 1'b0, 16'h0005, 8'h0d, 1'b1);
        jmp(8'he3, 1'b0, 1'b0, 16'h0000, 8'h0f, 1'b1);
        jmp(8'he3, 1'b0, 1'b0, 16'h0005, 8'h05, 1'b0);
        jmp(8'he2, 1'b0, 1'b0, 16'h0001, 8'h06, 1'b0);
        jmp(8'he2, 1'b0, 1'b0, 16'h0003, 8'h10, 1'b1);
        jmp(8'hce, 1'b0, 1'b1, 16'h0005, 8'h30, 1'b1);
        jmp(8'hce, 1'b0, 1'b0, 16'h0005, 8'h04, 1'b0);
        t_flags;
        t_misc;
        test_done;
    end
endmodule
